/* File: bench/tb.sv */
// Self-checking bench for the timing pattern register bank
`default_nettype none
module tb
	import tpn_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic        wr;
		logic [19:0] idx;
		logic [7:0]  val;
	} tpn_row_s;
	logic        SYS_CLK         = 1'b0;
	logic        RST_N           = 1'b0;
	logic        HW_STANDBY      = 1'b0;
	logic [2:0]  FIRE            = 3'h0;
	logic [3:0]  LAG             = 4'h0;
	logic [21:0] AVS_ADDRESS     = 22'h0;
	logic        AVS_READ        = 1'b0;
	logic        AVS_WRITE       = 1'b0;
	logic [3:0]  AVS_BYTEENABLE  = 4'hF;
	logic [31:0] AVS_WRITEDATA   = 32'h0;
	logic [2:0]  CMP_MATCH;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic [15:0] PATTERN_OUT;
	logic [15:0] PATTERN_OE;
	logic [7:0]  rd;
	int          n_mismatch      = 0;
	int          samples_checked = 0;
	// --------------------------------------------------------------
	// Register rows: write, or read with the value it must return
	// --------------------------------------------------------------
	tpn_row_s rows [25] = '{
		'{1'b0, TPN_IDX_MODE, 8'hF0}, '{1'b0, TPN_IDX_TRIG, 8'hFF},
		'{1'b0, TPN_IDX_EN_HI, 8'h00}, '{1'b0, TPN_IDX_EN_LO, 8'h00},
		'{1'b0, TPN_IDX_NXT_HI_PRI, 8'h00}, '{1'b0, TPN_IDX_NXT_LO_PRI, 8'h00},
		'{1'b0, TPN_IDX_NXT_HI_ALT, 8'hFF}, '{1'b0, TPN_IDX_NXT_LO_ALT, 8'hFF},
		'{1'b0, TPN_IDX_DAT_A, 8'h00}, '{1'b0, TPN_IDX_DAT_B, 8'h00},
		'{1'b0, TPN_IDX_DIR_A, 8'h00}, '{1'b0, 20'h12345, 8'h00},
		'{1'b1, TPN_IDX_NXT_LO_ALT, 8'h00}, '{1'b0, TPN_IDX_NXT_LO_ALT, 8'hFF},
		'{1'b1, TPN_IDX_NXT_HI_ALT, 8'h55}, '{1'b0, TPN_IDX_NXT_HI_PRI, 8'h00},
		'{1'b1, TPN_IDX_MODE, 8'h3C}, '{1'b0, TPN_IDX_MODE, 8'h3C},
		'{1'b1, TPN_IDX_DAT_A, 8'hA5}, '{1'b0, TPN_IDX_DAT_A, 8'hA5},
		'{1'b1, TPN_IDX_DIR_A, 8'hFF}, '{1'b1, TPN_IDX_DIR_B, 8'hFF},
		'{1'b1, 20'h12345, 8'h77}, '{1'b0, 20'h12345, 8'h00},
		'{1'b0, TPN_IDX_DIR_B, 8'h00}};
	// Free-running system clock, 10 ns period
	always #5 SYS_CLK = ~SYS_CLK;
	tpn_bank uut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HW_STANDBY(HW_STANDBY),
		.CMP_MATCH(CMP_MATCH), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.PATTERN_OUT(PATTERN_OUT), .PATTERN_OE(PATTERN_OE));
	tpn_timer_model u_tmr (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .FIRE(FIRE),
		.LAG(LAG), .CMP_MATCH(CMP_MATCH));
	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	// Verdict and the single end of the run
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// A used-up wait counts as a mismatch and ends the run
	task automatic waited(int n);
		if (n >= 50) begin
			n_mismatch++;
			$display("[FAIL] wait expected done seen timeout");
			report_and_stop();
		end
	endtask
	task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_pin(string nm, logic [15:0] e, logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(logic wr, logic [19:0] idx, logic [7:0] wd);
		int n;
		@(posedge SYS_CLK);
		AVS_ADDRESS   <= {idx, 2'b00};
		AVS_WRITEDATA <= {24'h0, wd};
		AVS_READ      <= !wr;
		AVS_WRITE     <= wr;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
		rd = AVS_READDATA[7:0];
		AVS_READ  <= 1'b0;
		AVS_WRITE <= 1'b0;
		waited(n);
	endtask
	task automatic rdchk(logic [19:0] idx, logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		chk_reg($sformatf("reg %h", idx), e, rd);
	endtask
	// Ask the timer for a pulse; return just after the edge that took it
	task automatic pulse(logic [2:0] m);
		int n;
		@(posedge SYS_CLK);
		FIRE <= m;
		@(posedge SYS_CLK);
		FIRE <= 3'h0;
		n = 0;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (CMP_MATCH !== m && n < 50);
		waited(n);
		#1;
	endtask
	// --------------------------------------------------------------
	// Sequence
	// --------------------------------------------------------------
	initial begin
		repeat (10) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		#1;
		chk_pin("pins", 16'h0000, PATTERN_OUT);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].idx, rows[i].val);
			if (!rows[i].wr) begin
				chk_reg($sformatf("row %0d", i), rows[i].val, rd);
			end
		end
		@(posedge SYS_CLK);
		#1;
		chk_pin("pins", 16'h00A5, PATTERN_OUT);
		chk_pin("enable", 16'hFFFF, PATTERN_OE);
		// Shared trigger, mixed per-bit enables
		bus(1'b1, TPN_IDX_TRIG, 8'hF0);
		bus(1'b1, TPN_IDX_EN_LO, 8'h3C);
		bus(1'b1, TPN_IDX_NXT_LO_PRI, 8'hFF);
		pulse(3'h1);
		chk_pin("shared", 16'h00BD, PATTERN_OUT);
		// Split triggers in each pair; groups 0 and 3 share channel 1
		bus(1'b1, TPN_IDX_TRIG, 8'h49);
		bus(1'b1, TPN_IDX_EN_LO, 8'hFF);
		bus(1'b1, TPN_IDX_EN_HI, 8'hFF);
		bus(1'b1, TPN_IDX_NXT_LO_PRI, 8'h60);
		bus(1'b1, TPN_IDX_NXT_LO_ALT, 8'h03);
		bus(1'b1, TPN_IDX_NXT_HI_PRI, 8'hC0);
		bus(1'b1, TPN_IDX_NXT_HI_ALT, 8'h0A);
		rdchk(TPN_IDX_NXT_LO_PRI, 8'h6F);
		rdchk(TPN_IDX_NXT_LO_ALT, 8'hF3);
		rdchk(TPN_IDX_NXT_HI_PRI, 8'hCF);
		rdchk(TPN_IDX_NXT_HI_ALT, 8'hFA);
		pulse(3'h2);
		chk_pin("ch1", 16'hC0B3, PATTERN_OUT);
		LAG <= 4'h5;
		pulse(3'h4);
		chk_pin("ch2", 16'hC063, PATTERN_OUT);
		pulse(3'h1);
		chk_pin("ch0", 16'hCA63, PATTERN_OUT);
		// Enabled port bits refuse software writes
		bus(1'b1, TPN_IDX_DAT_A, 8'h00);
		rdchk(TPN_IDX_DAT_A, 8'h63);
		bus(1'b1, TPN_IDX_EN_HI, 8'h0F);
		bus(1'b1, TPN_IDX_DAT_B, 8'h35);
		rdchk(TPN_IDX_DAT_B, 8'h3A);
		// Group 3 set to no trigger holds while the others fire
		bus(1'b1, TPN_IDX_EN_HI, 8'hFF);
		bus(1'b1, TPN_IDX_TRIG, 8'hC9);
		pulse(3'h7);
		chk_pin("no trigger", 16'h3A63, PATTERN_OUT);
		// A write without byte lane 0 changes nothing
		AVS_BYTEENABLE <= 4'hE;
		bus(1'b1, TPN_IDX_MODE, 8'h11);
		AVS_BYTEENABLE <= 4'hF;
		rdchk(TPN_IDX_MODE, 8'h3C);
		// Hardware standby clears enables and next data only
		@(posedge SYS_CLK);
		HW_STANDBY <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		HW_STANDBY <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		rdchk(TPN_IDX_EN_LO, 8'h00);
		rdchk(TPN_IDX_EN_HI, 8'h00);
		rdchk(TPN_IDX_NXT_HI_PRI, 8'h0F);
		rdchk(TPN_IDX_NXT_LO_ALT, 8'hF0);
		rdchk(TPN_IDX_MODE, 8'h3C);
		pulse(3'h7);
		chk_pin("disabled", 16'h3A63, PATTERN_OUT);
		// Reset again in mid-run
		@(posedge SYS_CLK);
		RST_N <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		#1;
		chk_pin("pins", 16'h0000, PATTERN_OUT);
		chk_pin("enable", 16'h0000, PATTERN_OE);
		rdchk(TPN_IDX_TRIG, 8'hFF);
		report_and_stop();
	end
endmodule
`default_nettype wire

/* File: bench/tpn_timer_model.sv */
// Timer model: compare-match pulses on request, after a chosen lag
`default_nettype none
module tpn_timer_model (
	input  wire logic       SYS_CLK,
	input  wire logic       RST_N,
	input  wire logic [2:0] FIRE,
	input  wire logic [3:0] LAG,
	output logic [2:0]      CMP_MATCH
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] pend;
	logic [3:0] cnt;
	// --------------------------------------------------------------
	// Pulse generator
	// --------------------------------------------------------------
	// Arm on a request; lag lets the bench try prompt and slow timers
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pend      <= 3'h0;
			cnt       <= 4'h0;
			CMP_MATCH <= 3'h0;
		end else begin
			CMP_MATCH <= 3'h0; // never longer than one cycle
			if (FIRE != 3'h0) begin
				pend <= FIRE;
				cnt  <= LAG;
			end else if (pend != 3'h0 && cnt == 4'h0) begin
				CMP_MATCH <= pend;
				pend      <= 3'h0;
			end else if (pend != 3'h0) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/tpn_bank.sv */
// Timing pattern register bank with compare-match transfer path
`default_nettype none
module tpn_bank
	import tpn_pkg::*;
#(
	parameter int ADDR_W = 22,
	parameter int CMP_W  = 3
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	input  wire logic              HW_STANDBY,
	input  wire logic [CMP_W-1:0]  CMP_MATCH,
	input  wire logic [ADDR_W-1:0] AVS_ADDRESS,
	input  wire logic              AVS_READ,
	input  wire logic              AVS_WRITE,
	input  wire logic [3:0]        AVS_BYTEENABLE,
	input  wire logic [31:0]       AVS_WRITEDATA,
	output logic [31:0]            AVS_READDATA,
	output logic                   AVS_WAITREQUEST,
	output logic [15:0]            PATTERN_OUT,
	output logic [15:0]            PATTERN_OE
);
	// ------------------------------------------------------------
	// Storage; index 0 is the low pair (A), 1 the high pair (B)
	// ------------------------------------------------------------
	logic [7:0]           dir      [TPN_PAIRS];
	logic [7:0]           port_dat [TPN_PAIRS];
	logic [7:0]           xfer_en  [TPN_PAIRS];
	logic [7:0]           next_pat [TPN_PAIRS];
	logic [7:0]           fire_mask[TPN_PAIRS];
	logic [7:0]           sw_mask  [TPN_PAIRS];
	logic [7:0]           next_port[TPN_PAIRS];
	logic [7:0]           mode;
	logic [7:0]           trig;
	logic [TPN_GROUPS-1:0] fire;
	logic [TPN_PAIRS-1:0] shared;
	logic                 stby_s1;
	logic                 stby_s2;
	logic [TPN_IDX_W-1:0] idx;
	logic                 wr_go;
	logic                 rd_cap;
	logic [7:0]           rd_val;
	logic [7:0]           wdat;

	localparam logic [19:0] PRI_IDX[TPN_PAIRS] =
		'{TPN_IDX_NXT_LO_PRI, TPN_IDX_NXT_HI_PRI};
	localparam logic [19:0] ALT_IDX[TPN_PAIRS] =
		'{TPN_IDX_NXT_LO_ALT, TPN_IDX_NXT_HI_ALT};
	localparam logic [19:0] DAT_IDX[TPN_PAIRS] =
		'{TPN_IDX_DAT_A, TPN_IDX_DAT_B};
	localparam logic [19:0] EN_IDX[TPN_PAIRS] =
		'{TPN_IDX_EN_LO, TPN_IDX_EN_HI};
	localparam logic [19:0] DIR_IDX[TPN_PAIRS] =
		'{TPN_IDX_DIR_A, TPN_IDX_DIR_B};

	// ------------------------------------------------------------
	// Views of a next-data pair at its two addresses
	// ------------------------------------------------------------
	function automatic logic [7:0] pri_view(input logic [7:0] nd,
		input logic sh);
		pri_view = sh ? nd : {nd[7:4], TPN_NIB_ONES};
	endfunction

	function automatic logic [7:0] alt_view(input logic [7:0] nd,
		input logic sh);
		alt_view = sh ? TPN_ALL_ONES : {TPN_NIB_ONES, nd[3:0]};
	endfunction

	// ------------------------------------------------------------
	// Standby pin synchroniser and bus decode
	// ------------------------------------------------------------
	// Standby comes from a pin, so two flops before use
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			stby_s1 <= 1'b0;
			stby_s2 <= 1'b0;
		end else begin
			stby_s1 <= HW_STANDBY;
			stby_s2 <= stby_s1;
		end
	end

	// The two lowest address bits are ignored on purpose
	assign idx = AVS_ADDRESS[TPN_IDX_W+TPN_ADDR_LSB-1:TPN_ADDR_LSB];
	assign wdat = AVS_WRITEDATA[7:0];
	// Writes land on the edge where waitrequest is seen low
	assign wr_go = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	assign rd_cap = AVS_READ && AVS_WAITREQUEST;

	// One wait cycle per access, then release
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			AVS_WAITREQUEST <= 1'b1;
		end else if (!AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else if (AVS_READ || AVS_WRITE) begin
			AVS_WAITREQUEST <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Trigger selection, one two-bit field per group
	// ------------------------------------------------------------
	// Code 3 selects no trigger, so the reset value leaves all idle
	for (genvar g = 0; g < TPN_GROUPS; g++) begin : g_fire
		logic [TPN_SEL_W-1:0] sel;
		assign sel = trig[TPN_SEL_W*g +: TPN_SEL_W];
		assign fire[g] = (sel != TPN_TRIG_NONE) &&
			CMP_MATCH[sel];
	end

	// ------------------------------------------------------------
	// Per-pair registers and transfer path
	// ------------------------------------------------------------
	for (genvar p = 0; p < TPN_PAIRS; p++) begin : g_pair
		// Groups of a pair share one view when their triggers agree
		assign shared[p] = trig[TPN_SEL_W*(2*p) +: TPN_SEL_W] ==
			trig[TPN_SEL_W*(2*p+1) +: TPN_SEL_W];
		// Only enabled bits of a firing group move
		assign fire_mask[p] = {{TPN_NIB_W{fire[2*p+1]}},
			{TPN_NIB_W{fire[2*p]}}} & xfer_en[p];
		// Software reaches only bits not used for pattern output
		assign sw_mask[p] = (wr_go && idx == DAT_IDX[p]) ?
			~xfer_en[p] : TPN_RST_ZERO;
		assign next_port[p] = (port_dat[p] & ~fire_mask[p] & ~sw_mask[p])
			| (next_pat[p] & fire_mask[p])
			| (wdat & sw_mask[p]);

		// Port data; holds the live output levels
		always_ff @(posedge SYS_CLK) begin
			if (!RST_N) begin
				port_dat[p] <= TPN_RST_ZERO;
			end else begin
				port_dat[p] <= next_port[p];
			end
		end

		// Direction bits steer the pin drivers
		always_ff @(posedge SYS_CLK) begin
			if (!RST_N) begin
				dir[p] <= TPN_RST_ZERO;
			end else if (wr_go && idx == DIR_IDX[p]) begin
				dir[p] <= wdat;
			end
		end

		// Enables survive software standby, not hardware standby
		always_ff @(posedge SYS_CLK) begin
			if (!RST_N || stby_s2) begin
				xfer_en[p] <= TPN_RST_ZERO;
			end else if (wr_go && idx == EN_IDX[p]) begin
				xfer_en[p] <= wdat;
			end
		end

		// Next data; the address map follows the trigger sharing
		always_ff @(posedge SYS_CLK) begin
			if (!RST_N || stby_s2) begin
				next_pat[p] <= TPN_RST_ZERO;
			end else if (wr_go && idx == PRI_IDX[p]) begin
				if (shared[p]) begin
					next_pat[p] <= wdat;
				end else begin
					next_pat[p][7:4] <= wdat[7:4];
				end
			end else if (wr_go && idx == ALT_IDX[p] && !shared[p]) begin
				next_pat[p][3:0] <= wdat[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Mode and trigger select registers
	// ------------------------------------------------------------
	// Non-overlap bits are stored only; no waveform logic uses them
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			mode <= TPN_RST_MODE;
		end else if (wr_go && idx == TPN_IDX_MODE) begin
			mode <= wdat;
		end
	end

	// Trigger fields pick a compare-match channel per group
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			trig <= TPN_RST_TRIG;
		end else if (wr_go && idx == TPN_IDX_TRIG) begin
			trig <= wdat;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Direction registers are write-only and read as zero
	always_comb begin
		rd_val = TPN_RST_ZERO;
		if (idx == TPN_IDX_MODE) begin
			rd_val = mode;
		end else if (idx == TPN_IDX_TRIG) begin
			rd_val = trig;
		end else if (idx == TPN_IDX_EN_HI) begin
			rd_val = xfer_en[1];
		end else if (idx == TPN_IDX_EN_LO) begin
			rd_val = xfer_en[0];
		end else if (idx == TPN_IDX_NXT_HI_PRI) begin
			rd_val = pri_view(next_pat[1], shared[1]);
		end else if (idx == TPN_IDX_NXT_LO_PRI) begin
			rd_val = pri_view(next_pat[0], shared[0]);
		end else if (idx == TPN_IDX_NXT_HI_ALT) begin
			rd_val = alt_view(next_pat[1], shared[1]);
		end else if (idx == TPN_IDX_NXT_LO_ALT) begin
			rd_val = alt_view(next_pat[0], shared[0]);
		end else if (idx == TPN_IDX_DAT_A) begin
			rd_val = port_dat[0];
		end else if (idx == TPN_IDX_DAT_B) begin
			rd_val = port_dat[1];
		end
	end

	// Read data captured at the edge that drops waitrequest, stable while released
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (rd_cap) begin
			AVS_READDATA <= {24'h00_0000, rd_val};
		end
	end

	// ------------------------------------------------------------
	// Pins: data and enables straight from the registers
	// ------------------------------------------------------------
	assign PATTERN_OUT = {port_dat[1], port_dat[0]};
	assign PATTERN_OE  = {dir[1], dir[0]};

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_req_taken;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence

	sequence s_lo_alt_read_shared;
		rd_cap && idx == TPN_IDX_NXT_LO_ALT && shared[0];
	endsequence

	a_bus_release: assert property (s_req_taken |=> AVS_WAITREQUEST)
		else $error("waitrequest not raised after access");

	a_bus_answer: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("access not answered in one cycle");

	a_lo_copy: assert property (
		fire_mask[0] != TPN_RST_ZERO |=>
		((port_dat[0] ^ $past(next_pat[0])) & $past(fire_mask[0]))
		== TPN_RST_ZERO)
		else $error("low next data not copied");

	a_hi_copy: assert property (
		fire_mask[1] != TPN_RST_ZERO |=>
		((port_dat[1] ^ $past(next_pat[1])) & $past(fire_mask[1]))
		== TPN_RST_ZERO)
		else $error("high next data not copied");

	a_a_read_only: assert property (
		wr_go && idx == TPN_IDX_DAT_A && fire[1:0] == 2'b00 |=>
		((port_dat[0] ^ $past(port_dat[0])) & $past(xfer_en[0]))
		== TPN_RST_ZERO)
		else $error("enabled port A bit was written");

	a_b_read_only: assert property (
		wr_go && idx == TPN_IDX_DAT_B && fire[3:2] == 2'b00 |=>
		((port_dat[1] ^ $past(port_dat[1])) & $past(xfer_en[1]))
		== TPN_RST_ZERO)
		else $error("enabled port B bit was written");

	a_hold_unfired: assert property (
		!(wr_go && idx == TPN_IDX_DAT_A) |=>
		((port_dat[0] ^ $past(port_dat[0])) & ~$past(fire_mask[0]))
		== TPN_RST_ZERO)
		else $error("port A bit moved without cause");

	a_stby_clear: assert property (
		stby_s2 |=> next_pat[0] == TPN_RST_ZERO &&
		next_pat[1] == TPN_RST_ZERO && xfer_en[0] == TPN_RST_ZERO &&
		xfer_en[1] == TPN_RST_ZERO)
		else $error("standby did not clear next data or enables");

	a_rsvd_ones: assert property (
		s_lo_alt_read_shared |=> AVS_READDATA[7:0] == TPN_ALL_ONES)
		else $error("reserved address did not read ones");

	a_split_view: assert property (
		rd_cap && idx == TPN_IDX_NXT_LO_PRI && !shared[0] |=>
		AVS_READDATA[3:0] == TPN_NIB_ONES &&
		AVS_READDATA[7:4] == $past(next_pat[0][7:4]))
		else $error("split low view wrong");

	a_shared_view: assert property (
		rd_cap && idx == TPN_IDX_NXT_HI_PRI && shared[1] |=>
		AVS_READDATA[7:0] == $past(next_pat[1]))
		else $error("shared high view wrong");

	// Port B bits move only when their group fires or software writes them
	a_hold_unfired_b: assert property (
		!(wr_go && idx == TPN_IDX_DAT_B) |=>
		((port_dat[1] ^ $past(port_dat[1])) & ~$past(fire_mask[1]))
		== TPN_RST_ZERO)
		else $error("port B bit moved without cause");

	// Waitrequest stays high while the bus is idle
	a_bus_idle: assert property (
		!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest dropped with no request");

	// Read data holds between captures so a slow master still sees it
	a_rd_hold: assert property (!rd_cap |=> $stable(AVS_READDATA))
		else $error("read data changed without a read");

	// Upper read lanes carry nothing
	a_rd_upper: assert property (AVS_READDATA[31:8] == 24'h00_0000)
		else $error("upper read lanes not zero");

	// Shared low pair: the alternate address takes no writes
	a_lo_alt_locked: assert property (
		wr_go && idx == TPN_IDX_NXT_LO_ALT && shared[0] &&
		!stby_s2 |=> next_pat[0] == $past(next_pat[0]))
		else $error("reserved low next-data address took a write");

	// Shared high pair: the alternate address takes no writes
	a_hi_alt_locked: assert property (
		wr_go && idx == TPN_IDX_NXT_HI_ALT && shared[1] &&
		!stby_s2 |=> next_pat[1] == $past(next_pat[1]))
		else $error("reserved high next-data address took a write");

	// Split pairs: a primary write leaves group 0 alone
	a_split_write: assert property (
		wr_go && idx == TPN_IDX_NXT_LO_PRI && !shared[0] &&
		!stby_s2 |=> next_pat[0][3:0] == $past(next_pat[0][3:0]))
		else $error("split primary write reached group 0");

	sequence s_dat_a_write;
		wr_go && idx == TPN_IDX_DAT_A && fire[1:0] == 2'b00;
	endsequence

	// Bits free of pattern output take the written value
	a_a_write: assert property (
		s_dat_a_write |=>
		((port_dat[0] ^ $past(wdat)) & ~$past(xfer_en[0]))
		== TPN_RST_ZERO)
		else $error("free port A bit ignored a write");

	// Direction writes land whole; they steer the pin enables
	a_dir_write: assert property (
		wr_go && idx == TPN_IDX_DIR_A |=> dir[0] == $past(wdat))
		else $error("port A direction write lost");

	// Enable writes land whole unless standby clears them
	a_en_write: assert property (
		wr_go && idx == TPN_IDX_EN_LO && !stby_s2 |=>
		xfer_en[0] == $past(wdat))
		else $error("low enable write lost");

	// Standby reaches the registers two edges after the pin
	a_stby_sync: assert property (HW_STANDBY |-> ##2 stby_s2)
		else $error("standby not seen after two edges");

	// A group with no trigger holds its pins unless software writes
	for (genvar g = 0; g < TPN_GROUPS; g++) begin : g_chk_idle
		a_idle_group: assert property (
			g_fire[g].sel == TPN_TRIG_NONE &&
			!(wr_go && idx == DAT_IDX[g/2]) |=>
			port_dat[g/2][TPN_NIB_W*(g%2) +: TPN_NIB_W] ==
			$past(port_dat[g/2][TPN_NIB_W*(g%2) +: TPN_NIB_W]))
			else $error("group without trigger changed its pins");
	end
endmodule
`default_nettype wire

/* File: rtl/tpn_pkg.sv */
// Constants for the timing pattern next-data register bank
`default_nettype none
package tpn_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam int          TPN_IDX_W          = 20;
	localparam int          TPN_ADDR_LSB       = 2;
	localparam logic [19:0] TPN_IDX_DIR_A      = 20'hEE009;
	localparam logic [19:0] TPN_IDX_DIR_B      = 20'hEE00A;
	localparam logic [19:0] TPN_IDX_MODE       = 20'hFFFA0;
	localparam logic [19:0] TPN_IDX_TRIG       = 20'hFFFA1;
	localparam logic [19:0] TPN_IDX_EN_HI      = 20'hFFFA2;
	localparam logic [19:0] TPN_IDX_EN_LO      = 20'hFFFA3;
	localparam logic [19:0] TPN_IDX_NXT_HI_PRI = 20'hFFFA4;
	localparam logic [19:0] TPN_IDX_NXT_LO_PRI = 20'hFFFA5;
	localparam logic [19:0] TPN_IDX_NXT_HI_ALT = 20'hFFFA6;
	localparam logic [19:0] TPN_IDX_NXT_LO_ALT = 20'hFFFA7;
	localparam logic [19:0] TPN_IDX_DAT_A      = 20'hFFFD9;
	localparam logic [19:0] TPN_IDX_DAT_B      = 20'hFFFDA;
	// ------------------------------------------------------------
	// Reset values and field layout
	// ------------------------------------------------------------
	localparam logic [7:0]  TPN_RST_MODE       = 8'hF0;
	localparam logic [7:0]  TPN_RST_TRIG       = 8'hFF;
	localparam logic [7:0]  TPN_RST_ZERO       = 8'h00;
	localparam logic [7:0]  TPN_ALL_ONES       = 8'hFF;
	localparam logic [3:0]  TPN_NIB_ONES       = 4'hF;
	localparam logic [1:0]  TPN_TRIG_NONE      = 2'h3;
	localparam int          TPN_SEL_W          = 2;
	localparam int          TPN_NIB_W          = 4;
	localparam int          TPN_GROUPS         = 4;
	localparam int          TPN_PAIRS          = 2;
endpackage
`default_nettype wire
